// [common/pwr_seq_pkg.sv]
// Constants and types of the sleep and wake power sequencer
package pwr_seq_pkg;
	// Register offsets
	localparam logic [7:0] OFF_GEN_CTRL = 8'h00;
	localparam logic [7:0] OFF_WAKE_TIME_LOW = 8'h04;
	localparam logic [7:0] OFF_WAKE_TIME_HIGH = 8'h08;
	localparam logic [7:0] OFF_LOW_POWER_CFG = 8'h0C;
	localparam logic [7:0] OFF_WAKE_ONE_CFG = 8'h10;
	localparam logic [7:0] OFF_WAKE_TWO_CFG = 8'h14;
	// General control bit positions
	localparam int GEN_SLEEP_CLK_BIT = 0;
	localparam int GEN_SLEEP_GO_BIT = 1;
	localparam int GEN_PIN_WAKE_BIT = 2;
	localparam int GEN_PIN_LEVEL_BIT = 3;
	localparam int GEN_RTC_WAKE_BIT = 4;
	localparam int GEN_WIDE_CMP_BIT = 5;
	localparam int GEN_POR_LEVEL_BIT = 7;
	localparam logic [7:0] GEN_RESET = 8'h08;
	// State word field positions
	localparam int CFG_DWELL_LSB = 16;
	localparam int CFG_DWELL_MSB = 20;
	localparam int CFG_CLK_STOP_BIT = 14;
	localparam int CFG_ANALOG_MOD_BIT = 9;
	localparam int CFG_CORE_MOD_BIT = 8;
	localparam int CFG_IO_EN_BIT = 5;
	localparam int CFG_PLL_EN_BIT = 4;
	localparam int CFG_ANALOG_EN_BIT = 1;
	localparam int CFG_CORE_EN_BIT = 0;
	localparam logic [4:0] DWELL_RESET = 5'h10;
	localparam logic [31:0] WAKE_TIME_RESET = 32'h0000_0000;

	typedef struct packed {
		logic [4:0] dwell;
		logic clk_stop;
		logic analog_pfm;
		logic core_pfm;
		logic io_en;
		logic pll_en;
		logic core_en;
	} cfg_t;

	typedef struct packed {
		logic tile_clk_stop;
		logic analog_pfm;
		logic core_pfm;
		logic io_en;
		logic pll_en;
		logic analog_en;
		logic core_en;
	} ctrl_t;

	typedef struct packed {
		logic io_good;
		logic pll_good;
		logic analog_good;
		logic core_good;
	} supply_t;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_LOW_POWER = 2'b01,
		ST_WAKE_ONE = 2'b10,
		ST_WAKE_TWO = 2'b11
	} seq_state_t;

	localparam cfg_t LOW_POWER_CFG_RESET = '{DWELL_RESET, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
	localparam cfg_t WAKE_ONE_CFG_RESET = '{DWELL_RESET, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
	localparam cfg_t WAKE_TWO_CFG_RESET = '{DWELL_RESET, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
	// Fixed analogue regulator enable per stage
	localparam logic LOW_POWER_ANALOG_EN = 1'b0;
	localparam logic WAKE_ONE_ANALOG_EN = 1'b0;
	localparam logic WAKE_TWO_ANALOG_EN = 1'b1;
	// Supply settings applied in the run state
	localparam ctrl_t RUN_CTRL = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage

// [hw/sleep_wake_power_sequencer.sv]
// Sleep and wake power sequencer with its register file
`timescale 1ns/100ps
// Function
// - Lower wake time word, 32-bit RW, reset zero, used when timer wake and asleep.
// - Upper wake time word, 32-bit RW, reset zero, compared only in 64-bit mode.
// - Low-power state holds its dwell, then leaves on timer or pin wake.
// - Dwell cycles are counted on the enabled clock, possibly the slow one.
// - Wake stages advance after dwell and all enabled supplies report good.
// - Dwell field bits 20:16, reset 16, means two to the N cycles.
// - Bit 14 of the current state word stops the tile clock.
// - Bits 9 and 8 pick analogue and core regulator modulation, 1 is PFM.
// - Bit 5 enables IO supply output, bit 4 the PLL linear regulator.
// - Bit 0 enables core regulator; bit 1 shows fixed analogue enable, read-only.
// - Control bit 4 enables timer wake; bit 5 selects 64-bit comparison.
// - Control bit 2 enables pin wake; bit 3, reset 1, selects high level.
// - Self-clearing control bit 1, set in run state, starts the sleep sequence.
module sleep_wake_power_sequencer (
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	input wire logic CE_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	output logic [31:0] REG_RDATA_O,
	input wire logic [63:0] RTC_COUNT_I,
	input wire logic WAKE_PIN_I,
	input wire pwr_seq_pkg::supply_t SUPPLY_GOOD_I,
	output pwr_seq_pkg::ctrl_t SUPPLY_CTRL_O,
	output pwr_seq_pkg::seq_state_t SEQ_STATE_O
);
	import pwr_seq_pkg::*;

	function automatic logic [31:0] dwell_mask(input logic [4:0] n);
		dwell_mask = (32'h0000_0001 << n) - 32'h0000_0001;
	endfunction

	function automatic logic [31:0] cfg_word(input cfg_t c, input logic analog_en);
		cfg_word = 32'h0000_0000;
		cfg_word[CFG_DWELL_MSB:CFG_DWELL_LSB] = c.dwell;
		cfg_word[CFG_CLK_STOP_BIT] = c.clk_stop;
		cfg_word[CFG_ANALOG_MOD_BIT] = c.analog_pfm;
		cfg_word[CFG_CORE_MOD_BIT] = c.core_pfm;
		cfg_word[CFG_IO_EN_BIT] = c.io_en;
		cfg_word[CFG_PLL_EN_BIT] = c.pll_en;
		cfg_word[CFG_ANALOG_EN_BIT] = analog_en;
		cfg_word[CFG_CORE_EN_BIT] = c.core_en;
	endfunction

	function automatic cfg_t cfg_from_word(input logic [31:0] w);
		cfg_from_word.dwell = w[CFG_DWELL_MSB:CFG_DWELL_LSB];
		cfg_from_word.clk_stop = w[CFG_CLK_STOP_BIT];
		cfg_from_word.analog_pfm = w[CFG_ANALOG_MOD_BIT];
		cfg_from_word.core_pfm = w[CFG_CORE_MOD_BIT];
		cfg_from_word.io_en = w[CFG_IO_EN_BIT];
		cfg_from_word.pll_en = w[CFG_PLL_EN_BIT];
		cfg_from_word.core_en = w[CFG_CORE_EN_BIT];
	endfunction

	function automatic ctrl_t cfg_ctrl(input cfg_t c, input logic analog_en);
		cfg_ctrl = '{c.clk_stop, c.analog_pfm, c.core_pfm, c.io_en, c.pll_en, analog_en, c.core_en};
	endfunction

	// Register file
	logic [7:0] gen_q, gen_d;
	logic [31:0] wake_lo_q, wake_lo_d, wake_hi_q, wake_hi_d, rdata_q, rdata_d;
	cfg_t low_q, low_d, one_q, one_d, two_q, two_d;
	// Sequencer
	seq_state_t state_q, state_d;
	logic [31:0] cnt_q, cnt_d;
	ctrl_t ctrl_q, ctrl_d;
	// Synchronisers
	logic pin_s1_q, pin_s2_q;
	supply_t good_s1_q, good_s2_q;

	logic rtc_hit, pin_hit, dwell_done, supplies_ok;
	logic [4:0] cur_dwell;

	always_comb
	begin
		gen_d = gen_q;
		wake_lo_d = wake_lo_q;
		wake_hi_d = wake_hi_q;
		low_d = low_q;
		one_d = one_q;
		two_d = two_q;
		rdata_d = rdata_q;
		if (state_q == ST_LOW_POWER)
		begin
			gen_d[GEN_SLEEP_GO_BIT] = 1'b0;
		end
		if (REG_WR_I)
		begin
			case (REG_ADDR_I)
				OFF_GEN_CTRL: gen_d = REG_WDATA_I[7:0] & 8'hBF;
				OFF_WAKE_TIME_LOW: wake_lo_d = REG_WDATA_I;
				OFF_WAKE_TIME_HIGH: wake_hi_d = REG_WDATA_I;
				OFF_LOW_POWER_CFG: low_d = cfg_from_word(REG_WDATA_I);
				OFF_WAKE_ONE_CFG: one_d = cfg_from_word(REG_WDATA_I);
				OFF_WAKE_TWO_CFG: two_d = cfg_from_word(REG_WDATA_I);
				default: ;
			endcase
		end
		if (REG_RD_I)
		begin
			case (REG_ADDR_I)
				OFF_GEN_CTRL: rdata_d = {24'h00_0000, gen_q};
				OFF_WAKE_TIME_LOW: rdata_d = wake_lo_q;
				OFF_WAKE_TIME_HIGH: rdata_d = wake_hi_q;
				OFF_LOW_POWER_CFG: rdata_d = cfg_word(low_q, LOW_POWER_ANALOG_EN);
				OFF_WAKE_ONE_CFG: rdata_d = cfg_word(one_q, WAKE_ONE_ANALOG_EN);
				OFF_WAKE_TWO_CFG: rdata_d = cfg_word(two_q, WAKE_TWO_ANALOG_EN);
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RST_I)
		begin
			gen_q <= GEN_RESET;
			wake_lo_q <= WAKE_TIME_RESET;
			wake_hi_q <= WAKE_TIME_RESET;
			low_q <= LOW_POWER_CFG_RESET;
			one_q <= WAKE_ONE_CFG_RESET;
			two_q <= WAKE_TWO_CFG_RESET;
			rdata_q <= 32'h0000_0000;
		end
		else if (CE_I)
		begin
			gen_q <= gen_d;
			wake_lo_q <= wake_lo_d;
			wake_hi_q <= wake_hi_d;
			low_q <= low_d;
			one_q <= one_d;
			two_q <= two_d;
			rdata_q <= rdata_d;
		end
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RST_I)
		begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			good_s1_q <= '0;
			good_s2_q <= '0;
		end
		else if (CE_I)
		begin
			pin_s1_q <= WAKE_PIN_I;
			pin_s2_q <= pin_s1_q;
			good_s1_q <= SUPPLY_GOOD_I;
			good_s2_q <= good_s1_q;
		end
	end

	// Wake conditions
	always_comb
	begin
		rtc_hit = gen_q[GEN_WIDE_CMP_BIT] ? (RTC_COUNT_I >= {wake_hi_q, wake_lo_q})
			: (RTC_COUNT_I[31:0] >= wake_lo_q);
		rtc_hit = rtc_hit & gen_q[GEN_RTC_WAKE_BIT];
		pin_hit = gen_q[GEN_PIN_WAKE_BIT] & (pin_s2_q == gen_q[GEN_PIN_LEVEL_BIT]);
		supplies_ok = (ctrl_q.io_en <= good_s2_q.io_good)
			& (ctrl_q.pll_en <= good_s2_q.pll_good)
			& (ctrl_q.analog_en <= good_s2_q.analog_good)
			& (ctrl_q.core_en <= good_s2_q.core_good);
		case (state_q)
			ST_LOW_POWER: cur_dwell = low_q.dwell;
			ST_WAKE_ONE: cur_dwell = one_q.dwell;
			ST_WAKE_TWO: cur_dwell = two_q.dwell;
			default: cur_dwell = 5'h00;
		endcase
		dwell_done = cnt_q >= dwell_mask(cur_dwell);
	end

	// Sequencer next state and applied settings
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_RUN: if (gen_q[GEN_SLEEP_GO_BIT])
				state_d = ST_LOW_POWER;
			ST_LOW_POWER: if (dwell_done && (rtc_hit || pin_hit))
				state_d = ST_WAKE_ONE;
			ST_WAKE_ONE: if (dwell_done && supplies_ok)
				state_d = ST_WAKE_TWO;
			ST_WAKE_TWO: if (dwell_done && supplies_ok)
				state_d = ST_RUN;
			default: state_d = ST_RUN;
		endcase
		cnt_d = cnt_q;
		if (state_d != state_q)
			cnt_d = 32'h0000_0000;
		else if (!dwell_done)
			cnt_d = cnt_q + 32'h0000_0001;
		case (state_d)
			ST_LOW_POWER: ctrl_d = cfg_ctrl(low_q, LOW_POWER_ANALOG_EN);
			ST_WAKE_ONE: ctrl_d = cfg_ctrl(one_q, WAKE_ONE_ANALOG_EN);
			ST_WAKE_TWO: ctrl_d = cfg_ctrl(two_q, WAKE_TWO_ANALOG_EN);
			default: ctrl_d = RUN_CTRL;
		endcase
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RST_I)
		begin
			state_q <= ST_RUN;
			cnt_q <= 32'h0000_0000;
			ctrl_q <= RUN_CTRL;
		end
		else if (CE_I)
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			ctrl_q <= ctrl_d;
		end
	end

	assign REG_RDATA_O = rdata_q;
	assign SUPPLY_CTRL_O = ctrl_q;
	assign SEQ_STATE_O = state_q;

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);

	property p_wake_low_write;
		CE_I && REG_WR_I && REG_ADDR_I == OFF_WAKE_TIME_LOW |=> wake_lo_q == $past(REG_WDATA_I);
	endproperty
	a_wake_low_write: assert property (p_wake_low_write)
		else $error("Lower wake time not stored");

	property p_narrow_compare;
		!gen_q[GEN_WIDE_CMP_BIT] && gen_q[GEN_RTC_WAKE_BIT]
			|-> rtc_hit == (RTC_COUNT_I[31:0] >= wake_lo_q);
	endproperty
	a_narrow_compare: assert property (p_narrow_compare)
		else $error("Narrow compare used upper word");

	property p_low_hold;
		CE_I && state_q == ST_LOW_POWER && cnt_q < dwell_mask(low_q.dwell) |=> state_q == ST_LOW_POWER;
	endproperty
	a_low_hold: assert property (p_low_hold)
		else $error("Low-power state left before dwell");

	property p_wake_one_hold;
		CE_I && state_q == ST_WAKE_ONE && !supplies_ok |=> state_q == ST_WAKE_ONE;
	endproperty
	a_wake_one_hold: assert property (p_wake_one_hold)
		else $error("Wake stage one left without good supplies");

	property p_clk_stop;
		$past(CE_I) && !$past(REG_WR_I) && state_q == ST_LOW_POWER |-> ctrl_q.tile_clk_stop == low_q.clk_stop;
	endproperty
	a_clk_stop: assert property (p_clk_stop)
		else $error("Tile clock stop differs from state word");

	property p_modulation;
		$past(CE_I) && !$past(REG_WR_I) && state_q == ST_WAKE_ONE
			|-> ctrl_q.analog_pfm == one_q.analog_pfm && ctrl_q.core_pfm == one_q.core_pfm;
	endproperty
	a_modulation: assert property (p_modulation)
		else $error("Modulation differs from state word");

	property p_supply_en;
		$past(CE_I) && !$past(REG_WR_I) && state_q == ST_WAKE_TWO
			|-> ctrl_q.io_en == two_q.io_en && ctrl_q.pll_en == two_q.pll_en && ctrl_q.analog_en;
	endproperty
	a_supply_en: assert property (p_supply_en)
		else $error("Supply enables differ in wake stage two");

	property p_sleep_start;
		CE_I && state_q == ST_RUN && gen_q[GEN_SLEEP_GO_BIT] |=> state_q == ST_LOW_POWER;
	endproperty
	a_sleep_start: assert property (p_sleep_start)
		else $error("Sleep request not taken");

	property p_sleep_clear;
		CE_I && state_q == ST_LOW_POWER && !(REG_WR_I && REG_ADDR_I == OFF_GEN_CTRL)
			|=> !gen_q[GEN_SLEEP_GO_BIT];
	endproperty
	a_sleep_clear: assert property (p_sleep_clear)
		else $error("Sleep request bit not cleared");

	property p_order;
		CE_I && state_q == ST_WAKE_ONE && dwell_done && supplies_ok |=> state_q == ST_WAKE_TWO;
	endproperty
	a_order: assert property (p_order)
		else $error("Wake stage one did not move to stage two");
endmodule

// [sim/sleep_wake_power_sequencer_bench.sv]
// Self-checking bench of the sleep and wake power sequencer
`timescale 1ns/100ps
module sleep_wake_power_sequencer_bench;
	import pwr_seq_pkg::*;
	logic CLK_SYS_I = 1'b0;
	logic RST_I = 1'b1;
	logic CE_I = 1'b1;
	logic REG_WR_I = 1'b0;
	logic REG_RD_I = 1'b0;
	logic [7:0] REG_ADDR_I = 8'h00;
	logic [31:0] REG_WDATA_I = 32'h0;
	logic [31:0] REG_RDATA_O;
	logic [63:0] RTC_COUNT_I = 64'h0;
	logic WAKE_PIN_I = 1'b0;
	supply_t SUPPLY_GOOD_I;
	ctrl_t SUPPLY_CTRL_O;
	seq_state_t SEQ_STATE_O;
	logic slow = 1'b0, stall = 1'b0, ce_rand = 1'b0, rd_q = 1'b0;
	int mismatches = 0, tests_run = 0, cnt = 0, n, k;
	int seed = 32'hD73E56A6;
	logic [31:0] exp_q[$];
	logic [31:0] r;
	logic [31:0] cfg[3];
	logic [31:0] rst_tab[7] = '{32'h8, 32'h0, 32'h0, 32'h00100000, 32'h00100020, 32'h00100033, 32'h0};
	always #12.5 CLK_SYS_I = ~CLK_SYS_I;
	sleep_wake_power_sequencer dut (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .CE_I(CE_I),
		.REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I),
		.REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .RTC_COUNT_I(RTC_COUNT_I),
		.WAKE_PIN_I(WAKE_PIN_I), .SUPPLY_GOOD_I(SUPPLY_GOOD_I), .SUPPLY_CTRL_O(SUPPLY_CTRL_O),
		.SEQ_STATE_O(SEQ_STATE_O));
	supply_model far (.clk_i(CLK_SYS_I), .ctrl_i(SUPPLY_CTRL_O), .slow_i(slow), .stall_i(stall),
		.good_o(SUPPLY_GOOD_I));
	always @(posedge CLK_SYS_I)
	begin
		CE_I <= ce_rand ? 1'($random(seed)) : 1'b1;
		rd_q <= REG_RD_I & CE_I;
		if (SEQ_STATE_O === ST_RUN)
			cnt <= 0;
		else if (SEQ_STATE_O === ST_LOW_POWER && CE_I === 1'b1)
			cnt <= cnt + 1;
	end
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask
	// Read data checker takes the oldest expectation
	always @(negedge CLK_SYS_I)
		if (rd_q)
			check("read data", exp_q.pop_front(), REG_RDATA_O);
	task automatic complete_run;
		check("read queue", 32'h0000_0000, 32'(exp_q.size()));
		$display("counts: %0d compares, %0d mismatches", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_SYS_I);
		REG_WR_I <= 1'b1;
		REG_ADDR_I <= a;
		REG_WDATA_I <= d;
		@(posedge CLK_SYS_I);
		REG_WR_I <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge CLK_SYS_I);
		REG_RD_I <= 1'b1;
		REG_ADDR_I <= a;
		exp_q.push_back(e);
		@(posedge CLK_SYS_I);
		REG_RD_I <= 1'b0;
	endtask
	function automatic ctrl_t exp_ctrl(input logic [31:0] w, input logic a);
		return '{w[14], w[9], w[8], w[5], w[4], a, w[0]};
	endfunction
	task automatic wait_state(input seq_state_t st, input ctrl_t e);
		int i;
		for (i = 0; i < 300 && SEQ_STATE_O !== st; i++)
			@(negedge CLK_SYS_I);
		check("state", 32'(st), 32'(SEQ_STATE_O));
		check("supply control", 32'(e), 32'(SUPPLY_CTRL_O));
		if (i == 300 && SEQ_STATE_O !== st)
			complete_run();
	endtask
	task automatic hold_low(input logic [31:0] c);
		wr(OFF_GEN_CTRL, c);
		wait_state(ST_LOW_POWER, exp_ctrl(cfg[0], 1'b0));
		repeat (20) @(negedge CLK_SYS_I);
		check("held state", 32'(ST_LOW_POWER), 32'(SEQ_STATE_O));
		@(posedge CLK_SYS_I);
	endtask
	initial
	begin
		repeat (16) @(posedge CLK_SYS_I);
		RST_I <= 1'b0;
		check("reset control", 32'(RUN_CTRL), 32'(SUPPLY_CTRL_O));
		for (k = 0; k < 7; k++)
			rd(8'(4 * k), rst_tab[k]);
		$display("reset values done");
		for (k = 1; k < 7; k++)
		begin
			r = $random(seed);
			cfg[k % 3] = r;
			wr(8'(4 * k), r);
			if (k < 3)
				rd(8'(4 * k), r);
			else if (k < 6)
				rd(8'(4 * k), (r & 32'h001F4331) | {30'h0, k == 5, 1'b0});
			else
				rd(8'(4 * k), 32'h0);
		end
		$display("register access done");
		wr(OFF_WAKE_TIME_LOW, 32'h0);
		wr(OFF_WAKE_TIME_HIGH, 32'h0);
		for (n = 0; n < 4; n++)
		begin
			for (k = 0; k < 3; k++)
			begin
				cfg[k] = ($random(seed) & 32'hFFE0FFFF) | ((k == 0) ? (n << 16) : 32'h20);
				wr(OFF_LOW_POWER_CFG + 8'(4 * k), cfg[k]);
			end
			slow <= n[0];
			stall <= (n == 2);
			RTC_COUNT_I <= {$random(seed), $random(seed)};
			wr(OFF_GEN_CTRL, 32'h12);
			ce_rand = 1'b1;
			wait_state(ST_LOW_POWER, exp_ctrl(cfg[0], 1'b0));
			wait_state(ST_WAKE_ONE, exp_ctrl(cfg[1], 1'b0));
			ce_rand = 1'b0;
			check("dwell count", 32'(1 << n), 32'(cnt));
			if (n == 2)
			begin
				repeat (20) @(negedge CLK_SYS_I);
				check("stalled state", 32'(ST_WAKE_ONE), 32'(SEQ_STATE_O));
				stall <= 1'b0;
			end
			wait_state(ST_WAKE_TWO, exp_ctrl(cfg[2], 1'b1));
			wait_state(ST_RUN, RUN_CTRL);
			rd(OFF_GEN_CTRL, 32'h10);
		end
		$display("sleep sequence done");
		wr(OFF_WAKE_TIME_HIGH, 32'h1);
		RTC_COUNT_I <= 64'h0000_0000_FFFF_FFFF;
		hold_low(32'h32);
		RTC_COUNT_I <= 64'h0000_0001_0000_0000;
		wait_state(ST_RUN, RUN_CTRL);
		WAKE_PIN_I <= 1'b1;
		hold_low(32'h06);
		WAKE_PIN_I <= 1'b0;
		wait_state(ST_RUN, RUN_CTRL);
		$display("wake sources done");
		repeat (4) @(posedge CLK_SYS_I);
		complete_run();
	end
endmodule

// [sim/supply_model.sv]
// Model of the supply regulators reporting good
`timescale 1ns/100ps
module supply_model (
	input wire logic clk_i,
	input wire pwr_seq_pkg::ctrl_t ctrl_i,
	input wire logic slow_i,
	input wire logic stall_i,
	output pwr_seq_pkg::supply_t good_o
);
	import pwr_seq_pkg::*;
	logic [3:0] en;
	logic [3:0] en_q = 4'h0;
	logic [3:0] cnt_q = 4'h0;
	assign en = {ctrl_i.io_en, ctrl_i.pll_en, ctrl_i.analog_en, ctrl_i.core_en};
	// Settle time restarts on any enable change
	always @(posedge clk_i)
	begin
		en_q <= en;
		cnt_q <= (en != en_q) ? 4'h0 : ((cnt_q == 4'hF) ? cnt_q : cnt_q + 4'h1);
	end
	// Disabled or stalled supplies read not good
	assign good_o = supply_t'((!stall_i && en == en_q && cnt_q >= (slow_i ? 4'h8 : 4'h1)) ? en_q : 4'h0);
endmodule
